// *** rtl/dtc_consts.svh ***
// Constants for the dual timer/event counter: register offsets, field positions, reset values
`ifndef DTC_CONSTS_SVH
`define DTC_CONSTS_SVH

`define DTC_OFS_IRQ_CTRL  8'h0b
`define DTC_OFS_C0_HIGH   8'h0c
`define DTC_OFS_C0_LOW    8'h0d
`define DTC_OFS_C0_CTRL   8'h0e
`define DTC_OFS_C1_HIGH   8'h0f
`define DTC_OFS_C1_LOW    8'h10
`define DTC_OFS_C1_CTRL   8'h11
`define DTC_OFS_PORT_A    8'h12

`define DTC_CTRL_RESET    8'h08
`define DTC_PORT_A_RESET  8'hff
`define DTC_CTRL0_MASK    8'hdf
`define DTC_CTRL1_MASK    8'hd8

`define DTC_BIT_RUN       4
`define DTC_BIT_EDGE      3
`define DTC_BIT_MODE_HI   7
`define DTC_BIT_MODE_LO   6
`define DTC_BIT_IEN0      2
`define DTC_BIT_IEN1      3
`define DTC_BIT_FLAG0     5
`define DTC_BIT_FLAG1     6
`define DTC_BIT_TONE      3

`define DTC_C1_PSC_SEL    3'h2
`define DTC_COUNT_MAX     16'hffff
`define DTC_COUNT_ONE     16'h0001
`define DTC_PSC_ONE       7'h01

`endif

// *** rtl/dtc_pkg.sv ***
// Types shared by the dual timer/event counter modules
package dtc_pkg;

  typedef enum logic [1:0] {
    DTC_MODE_OFF   = 2'b00,
    DTC_MODE_EVENT = 2'b01,
    DTC_MODE_TIMER = 2'b10,
    DTC_MODE_PULSE = 2'b11
  } dtc_mode_t;

  typedef enum logic [1:0] {
    DTC_PW_WAIT = 2'b01,
    DTC_PW_MEAS = 2'b10
  } dtc_pw_state_t;

  typedef struct packed {
    logic [15:0]   count;
    logic          pin;
    dtc_pw_state_t pw;
  } dtc_cnt_state_t;

  typedef struct packed {
    logic [1:0][7:0]  ctrl;
    logic [1:0][15:0] pre;
    logic [1:0][7:0]  hold;
    logic [1:0]       flag;
    logic [1:0]       ien;
    logic [7:0]       port_a;
    logic [6:0]       psc;
    logic [7:0]       rdata;
    logic             tone;
    logic             pin;
    logic [1:0]       irq;
    logic             wake;
    logic             pwm_tick;
  } dtc_top_state_t;

endpackage

// *** rtl/dtc_counter.sv ***
// One 16-bit up counter with event, timer and pulse-width modes
`include "dtc_consts.svh"

module dtc_counter (
  input  logic               mclk_in,
  input  logic               sys_rst_in,
  input  dtc_pkg::dtc_mode_t mode_in,
  input  logic               edge_sel_in,
  input  logic               run_in,
  input  logic               int_tick_in,
  input  logic               ext_pin_in,
  input  logic               block_in,
  input  logic               load_in,
  input  logic [15:0]        load_val_in,
  input  logic [15:0]        preload_in,
  output logic [15:0]        count_out,
  output logic               ovf_out,
  output logic               run_clr_out
);
  import dtc_pkg::*;

  dtc_cnt_state_t s_q;
  dtc_cnt_state_t s_d;
  logic           rise;
  logic           fall;
  logic           start_edge;
  logic           stop_edge;
  logic           step;

  always_comb begin
    s_d         = s_q;
    ovf_out     = 1'b0;
    run_clr_out = 1'b0;
    step        = 1'b0;
    rise        = ext_pin_in & ~s_q.pin;
    fall        = ~ext_pin_in & s_q.pin;
    start_edge  = edge_sel_in ? rise : fall;
    stop_edge   = edge_sel_in ? fall : rise;
    s_d.pin     = ext_pin_in;
    unique case (mode_in)
      DTC_MODE_EVENT: step = run_in & (edge_sel_in ? fall : rise);
      DTC_MODE_TIMER: step = run_in & int_tick_in;
      DTC_MODE_PULSE: step = run_in & (s_q.pw == DTC_PW_MEAS) & int_tick_in;
      DTC_MODE_OFF:   step = 1'b0;
    endcase
    // Only pulse-width mode ever asks for the run bit to drop
    if (!run_in || mode_in != DTC_MODE_PULSE) begin
      s_d.pw = DTC_PW_WAIT;
    end else begin
      unique case (s_q.pw)
        DTC_PW_WAIT: begin
          if (start_edge) begin
            s_d.pw = DTC_PW_MEAS;
          end
        end
        DTC_PW_MEAS: begin
          if (stop_edge) begin
            s_d.pw      = DTC_PW_WAIT;
            run_clr_out = 1'b1;
            step        = 1'b0;
          end
        end
        default: s_d.pw = DTC_PW_WAIT;
      endcase
    end
    // A read in progress swallows this count; the lost tick is accepted
    if (block_in) begin
      step = 1'b0;
    end
    if (load_in) begin
      s_d.count = load_val_in;
    end else if (step) begin
      if (s_q.count == `DTC_COUNT_MAX) begin
        s_d.count = preload_in;
        ovf_out   = 1'b1;
      end else begin
        s_d.count = s_q.count + `DTC_COUNT_ONE;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s_q <= '{count: 16'h0000, pin: 1'b0, pw: DTC_PW_WAIT};
    end else begin
      s_q <= s_d;
    end
  end

  assign count_out = s_q.count;

endmodule

// *** rtl/dtc_top.sv ***
// Top of the dual timer/event counter: register port, prescaler, flags, tone divider
`include "dtc_consts.svh"

module dtc_top #(
  parameter bit TONE_OPTION = 1'b1,
  parameter bit TONE_SRC    = 1'b0
) (
  input  logic       mclk_in,
  input  logic       sys_rst_in,
  input  logic [7:0] reg_addr_in,
  input  logic [7:0] reg_wdata_in,
  input  logic       reg_wr_in,
  input  logic       reg_rd_in,
  input  logic       counter0_pin_in,
  input  logic       counter1_pin_in,
  output logic [7:0] reg_rdata_out,
  output logic       port_a_bit3_pin_out,
  output logic       counter0_irq_out,
  output logic       counter1_irq_out,
  output logic       wake_out,
  output logic       pwm_clk_tick_out
);
  import dtc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  // Tick once per divisor period of the free-running prescaler
  function automatic logic psc_tick(input logic [6:0] cnt, input logic [2:0] sel);
    logic [6:0] mask;
    mask = 7'h00;
    unique case (sel)
      3'h0:    mask = 7'h01;
      3'h1:    mask = 7'h01;
      3'h2:    mask = 7'h03;
      3'h3:    mask = 7'h07;
      3'h4:    mask = 7'h0f;
      3'h5:    mask = 7'h1f;
      3'h6:    mask = 7'h3f;
      3'h7:    mask = 7'h7f;
    endcase
    psc_tick = ((cnt & mask) == mask);
  endfunction

  // Mode field of a control byte; code 00 leaves the counter idle
  function automatic dtc_mode_t mode_of(input logic [7:0] ctrl);
    mode_of = dtc_mode_t'(ctrl[`DTC_BIT_MODE_HI:`DTC_BIT_MODE_LO]);
  endfunction

  // Preload word formed by a high-byte write and the buffered low byte
  function automatic logic [15:0] pair_bytes(input logic [7:0] high, input logic [7:0] low);
    pair_bytes = {high, low};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State and decode

  dtc_top_state_t   s_q;
  dtc_top_state_t   s_d;

  logic             wr_irq;
  logic             wr_port_a;
  logic [1:0]       wr_high;
  logic [1:0]       wr_low;
  logic [1:0]       wr_ctrl;
  logic [1:0]       rd_high;
  logic [1:0]       rd_low;
  logic [1:0]       rd_ctrl;
  logic             rd_irq;
  logic             rd_port_a;

  logic [1:0]       run;
  logic [1:0]       edge_sel;
  logic [1:0]       load;
  logic [1:0]       tick;
  logic [1:0]       ovf;
  logic [1:0]       run_clr;
  logic             tone_ovf;
  dtc_mode_t        mode0;
  dtc_mode_t        mode1;
  logic [15:0]      count0;
  logic [15:0]      count1;
  logic [15:0]      load_val0;
  logic [15:0]      load_val1;

  always_comb begin
    wr_irq     = reg_wr_in & hit(reg_addr_in, `DTC_OFS_IRQ_CTRL);
    wr_port_a  = reg_wr_in & hit(reg_addr_in, `DTC_OFS_PORT_A);
    wr_high[0] = reg_wr_in & hit(reg_addr_in, `DTC_OFS_C0_HIGH);
    wr_high[1] = reg_wr_in & hit(reg_addr_in, `DTC_OFS_C1_HIGH);
    wr_low[0]  = reg_wr_in & hit(reg_addr_in, `DTC_OFS_C0_LOW);
    wr_low[1]  = reg_wr_in & hit(reg_addr_in, `DTC_OFS_C1_LOW);
    wr_ctrl[0] = reg_wr_in & hit(reg_addr_in, `DTC_OFS_C0_CTRL);
    wr_ctrl[1] = reg_wr_in & hit(reg_addr_in, `DTC_OFS_C1_CTRL);
    rd_irq     = reg_rd_in & hit(reg_addr_in, `DTC_OFS_IRQ_CTRL);
    rd_port_a  = reg_rd_in & hit(reg_addr_in, `DTC_OFS_PORT_A);
    rd_high[0] = reg_rd_in & hit(reg_addr_in, `DTC_OFS_C0_HIGH);
    rd_high[1] = reg_rd_in & hit(reg_addr_in, `DTC_OFS_C1_HIGH);
    rd_low[0]  = reg_rd_in & hit(reg_addr_in, `DTC_OFS_C0_LOW);
    rd_low[1]  = reg_rd_in & hit(reg_addr_in, `DTC_OFS_C1_LOW);
    rd_ctrl[0] = reg_rd_in & hit(reg_addr_in, `DTC_OFS_C0_CTRL);
    rd_ctrl[1] = reg_rd_in & hit(reg_addr_in, `DTC_OFS_C1_CTRL);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-counter controls from the control registers and writes; counter 1 prescaler select is fixed

  always_comb begin
    run[0]      = s_q.ctrl[0][`DTC_BIT_RUN];
    run[1]      = s_q.ctrl[1][`DTC_BIT_RUN];
    edge_sel[0] = s_q.ctrl[0][`DTC_BIT_EDGE];
    edge_sel[1] = s_q.ctrl[1][`DTC_BIT_EDGE];
    mode0       = mode_of(s_q.ctrl[0]);
    mode1       = mode_of(s_q.ctrl[1]);
    tick[0]     = psc_tick(s_q.psc, s_q.ctrl[0][2:0]);
    tick[1]     = psc_tick(s_q.psc, `DTC_C1_PSC_SEL);
    // Direct load only while stopped, otherwise the preload alone changes
    load[0]     = wr_high[0] & ~run[0];
    load[1]     = wr_high[1] & ~run[1];
    load_val0   = pair_bytes(reg_wdata_in, s_q.hold[0]);
    load_val1   = pair_bytes(reg_wdata_in, s_q.hold[1]);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // The two counters

  dtc_counter u_counter0 (
    .mclk_in     (mclk_in),
    .sys_rst_in  (sys_rst_in),
    .mode_in     (mode0),
    .edge_sel_in (edge_sel[0]),
    .run_in      (run[0]),
    .int_tick_in (tick[0]),
    .ext_pin_in  (counter0_pin_in),
    .block_in    (rd_high[0]),
    .load_in     (load[0]),
    .load_val_in (load_val0),
    .preload_in  (s_q.pre[0]),
    .count_out   (count0),
    .ovf_out     (ovf[0]),
    .run_clr_out (run_clr[0])
  );

  dtc_counter u_counter1 (
    .mclk_in     (mclk_in),
    .sys_rst_in  (sys_rst_in),
    .mode_in     (mode1),
    .edge_sel_in (edge_sel[1]),
    .run_in      (run[1]),
    .int_tick_in (tick[1]),
    .ext_pin_in  (counter1_pin_in),
    .block_in    (rd_high[1]),
    .load_in     (load[1]),
    .load_val_in (load_val1),
    .preload_in  (s_q.pre[1]),
    .count_out   (count1),
    .ovf_out     (ovf[1]),
    .run_clr_out (run_clr[1])
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_d     = s_q;
    s_d.psc = s_q.psc + `DTC_PSC_ONE;

    // Byte pairing: low byte goes to the holding buffer first
    if (wr_low[0]) begin
      s_d.hold[0] = reg_wdata_in;
    end
    if (wr_low[1]) begin
      s_d.hold[1] = reg_wdata_in;
    end
    if (wr_high[0]) begin
      s_d.pre[0] = load_val0;
    end
    if (wr_high[1]) begin
      s_d.pre[1] = load_val1;
    end

    // Hardware clear first so a software write in the same cycle still lands
    if (run_clr[0]) begin
      s_d.ctrl[0][`DTC_BIT_RUN] = 1'b0;
    end
    if (run_clr[1]) begin
      s_d.ctrl[1][`DTC_BIT_RUN] = 1'b0;
    end
    if (wr_ctrl[0]) begin
      s_d.ctrl[0] = reg_wdata_in & `DTC_CTRL0_MASK;
    end
    if (wr_ctrl[1]) begin
      s_d.ctrl[1] = reg_wdata_in & `DTC_CTRL1_MASK;
    end

    if (wr_port_a) begin
      s_d.port_a = reg_wdata_in;
    end

    // Flags: software may write either value, a fresh overflow always wins
    if (wr_irq) begin
      s_d.flag[0] = reg_wdata_in[`DTC_BIT_FLAG0];
      s_d.flag[1] = reg_wdata_in[`DTC_BIT_FLAG1];
      s_d.ien[0]  = reg_wdata_in[`DTC_BIT_IEN0];
      s_d.ien[1]  = reg_wdata_in[`DTC_BIT_IEN1];
    end
    s_d.flag = s_d.flag | ovf;
    s_d.irq  = s_d.flag & s_d.ien;
    s_d.wake = |ovf;

    s_d.pwm_tick = tick[0];

    // Tone divider: half the overflow rate of the chosen counter
    tone_ovf = TONE_SRC ? ovf[1] : ovf[0];
    if (tone_ovf) begin
      s_d.tone = ~s_q.tone;
    end
    if (TONE_OPTION) begin
      s_d.pin = s_d.port_a[`DTC_BIT_TONE] & s_d.tone;
    end else begin
      s_d.pin = s_d.port_a[`DTC_BIT_TONE];
    end

    // Read data lives for exactly one cycle after the strobe
    s_d.rdata = 8'h00;
    if (rd_high[0]) begin
      s_d.rdata   = count0[15:8];
      s_d.hold[0] = count0[7:0];
    end
    if (rd_high[1]) begin
      s_d.rdata   = count1[15:8];
      s_d.hold[1] = count1[7:0];
    end
    if (rd_low[0]) begin
      s_d.rdata = s_q.hold[0];
    end
    if (rd_low[1]) begin
      s_d.rdata = s_q.hold[1];
    end
    if (rd_ctrl[0]) begin
      s_d.rdata = s_q.ctrl[0];
    end
    if (rd_ctrl[1]) begin
      s_d.rdata = s_q.ctrl[1];
    end
    if (rd_irq) begin
      s_d.rdata[`DTC_BIT_FLAG0] = s_q.flag[0];
      s_d.rdata[`DTC_BIT_FLAG1] = s_q.flag[1];
      s_d.rdata[`DTC_BIT_IEN0]  = s_q.ien[0];
      s_d.rdata[`DTC_BIT_IEN1]  = s_q.ien[1];
    end
    if (rd_port_a) begin
      s_d.rdata = s_q.port_a;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s_q.ctrl     <= {`DTC_CTRL_RESET, `DTC_CTRL_RESET};
      s_q.pre      <= '0;
      s_q.hold     <= '0;
      s_q.flag     <= 2'h0;
      s_q.ien      <= 2'h0;
      s_q.port_a   <= `DTC_PORT_A_RESET;
      s_q.psc      <= 7'h00;
      s_q.rdata    <= 8'h00;
      s_q.tone     <= 1'b0;
      s_q.pin      <= 1'b0;
      s_q.irq      <= 2'h0;
      s_q.wake     <= 1'b0;
      s_q.pwm_tick <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rdata_out       = s_q.rdata;
  assign port_a_bit3_pin_out = s_q.pin;
  assign counter0_irq_out    = s_q.irq[0];
  assign counter1_irq_out    = s_q.irq[1];
  assign wake_out            = s_q.wake;
  assign pwm_clk_tick_out    = s_q.pwm_tick;

endmodule

// *** testbench/dtc_top_assertions.sv ***
// Port-level checks for the dual timer/event counter
module dtc_top_assertions (
  input logic       mclk_in,
  input logic       sys_rst_in,
  input logic [7:0] reg_addr_in,
  input logic [7:0] reg_wdata_in,
  input logic       reg_wr_in,
  input logic       reg_rd_in,
  input logic       counter0_pin_in,
  input logic       counter1_pin_in,
  input logic [7:0] reg_rdata_out,
  input logic       port_a_bit3_pin_out,
  input logic       counter0_irq_out,
  input logic       counter1_irq_out,
  input logic       wake_out,
  input logic       pwm_clk_tick_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  ////////////////////////////////////////////////////////////
  // Writes may reach pin and irq lines up to two edges late, so they are masked out for two edges
  logic [1:0] wr_q;
  logic [1:0] irqw_q;
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_q   <= 2'h0;
      irqw_q <= 2'h0;
    end else begin
      wr_q   <= {wr_q[0], reg_wr_in};
      irqw_q <= {irqw_q[0], reg_wr_in && reg_addr_in == 8'h0b};
    end
  end
  ////////////////////////////////////////////////////////////
  a_ctrl0_gap: assert property (reg_rd_in && reg_addr_in == 8'h0e |=> !reg_rdata_out[5])
    else $error("control 0 bit 5 not zero");
  a_ctrl1_bits: assert property (reg_rd_in && reg_addr_in == 8'h11
    |=> reg_rdata_out[2:0] == 3'h0 && !reg_rdata_out[5])
    else $error("control 1 unused bits not zero");
  a_tone_gate: assert property (reg_wr_in && reg_addr_in == 8'h12 && !reg_wdata_in[3]
    |-> ##2 !port_a_bit3_pin_out)
    else $error("tone pin not forced low");
  a_tone_step: assert property ($changed(port_a_bit3_pin_out) && wr_q == 2'h0 |-> wake_out)
    else $error("tone pin moved without overflow");
  a_wake_ovf0: assert property ($rose(counter0_irq_out) && wr_q == 2'h0 |-> wake_out)
    else $error("counter 0 overflow without wake");
  a_wake_ovf1: assert property ($rose(counter1_irq_out) && wr_q == 2'h0 |-> wake_out)
    else $error("counter 1 overflow without wake");
  a_irq_mask0: assert property (reg_wr_in && reg_addr_in == 8'h0b && !reg_wdata_in[2]
    |-> ##2 !counter0_irq_out)
    else $error("counter 0 irq not masked");
  a_irq_mask1: assert property (reg_wr_in && reg_addr_in == 8'h0b && !reg_wdata_in[3]
    |-> ##2 !counter1_irq_out)
    else $error("counter 1 irq not masked");
  a_flag_hold: assert property ($fell(counter0_irq_out) |-> irqw_q != 2'h0)
    else $error("request dropped without write");
  a_tick_gap: assert property (pwm_clk_tick_out |=> !pwm_clk_tick_out)
    else $error("prescaler tick two cycles long");
  c_wake: cover property (wake_out);
  c_irq1: cover property ($rose(counter1_irq_out));
  c_tone: cover property ($changed(port_a_bit3_pin_out));
endmodule

// *** testbench/dtc_pin_model.sv ***
// External event source: one synchronous high pulse of a chosen length per start
module dtc_pin_model (
  input  logic       mclk_in,
  input  logic       start_in,
  input  logic [7:0] width_in,
  output logic       pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q = 8'h00;
  // Short and long widths give prompt and slow edges; the line idles low
  always @(posedge mclk_in) begin
    if (start_in) begin
      cnt_q <= width_in;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
  assign pin_out = (cnt_q != 8'h00);
endmodule

// *** testbench/dtc_top_tb.sv ***
// Self-checking bench for the dual timer/event counter
module dtc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed { logic [7:0] val; logic [7:0] mask; } dtc_note_t;
  logic       mclk_in = 1'b0, sys_rst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0, rd_q = 1'b0;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, pin_width = 8'h00, reg_rdata_out;
  logic [1:0] pin_start = 2'h0;
  logic       counter0_pin_in, counter1_pin_in, port_a_bit3_pin_out;
  logic       counter0_irq_out, counter1_irq_out, wake_out, pwm_clk_tick_out;
  int         error_cnt = 0, checks = 0, seed = 46;
  dtc_note_t  notes[$];

  dtc_top #(.TONE_OPTION(1'b1), .TONE_SRC(1'b0)) dut_u (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .counter0_pin_in(counter0_pin_in),
    .counter1_pin_in(counter1_pin_in), .reg_rdata_out(reg_rdata_out), .port_a_bit3_pin_out(port_a_bit3_pin_out),
    .counter0_irq_out(counter0_irq_out), .counter1_irq_out(counter1_irq_out), .wake_out(wake_out),
    .pwm_clk_tick_out(pwm_clk_tick_out));
  dtc_pin_model pin0_u (.mclk_in(mclk_in), .start_in(pin_start[0]), .width_in(pin_width), .pin_out(counter0_pin_in));
  dtc_pin_model pin1_u (.mclk_in(mclk_in), .start_in(pin_start[1]), .width_in(pin_width), .pin_out(counter1_pin_in));

  initial begin
    forever #5 mclk_in = ~mclk_in;
  end
  ////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic fail(input string msg);
    $display("unexpected at %0t: %s", $time, msg);
    error_cnt++;
  endtask
  task automatic cmp_rd(input dtc_note_t n);
    checks++;
    if (((reg_rdata_out ^ n.val) & n.mask) !== 8'h00) fail("read data");
  endtask
  task automatic cmp_bit(input logic got, input logic exp, input string msg);
    checks++;
    if (got !== exp) fail(msg);
  endtask
  task automatic cmp_num(input int got, input int exp, input string msg);
    checks++;
    if (got != exp) fail(msg);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] v, input logic [7:0] m);
    notes.push_back('{v, m});
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
  endtask
  task automatic pulse(input logic [1:0] which, input logic [7:0] w);
    @(posedge mclk_in);
    pin_start <= which;
    pin_width <= w;
    @(posedge mclk_in);
    pin_start <= 2'h0;
  endtask
  task automatic wait_wake(output int n);
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (wake_out !== 1'b1 && n < 600);
    if (n >= 600) begin
      fail("no overflow");
      end_sim();
    end
  endtask
  // Two overflows are skipped so a prescaler phase left from the last setting cannot skew the interval
  task automatic period(input logic [7:0] a, input logic [7:0] v, input int exp, input logic tone);
    int   n;
    logic p;
    wr(a, v);
    wait_wake(n);
    wait_wake(n);
    p = port_a_bit3_pin_out;
    wait_wake(n);
    cmp_num(n, exp, "overflow period");
    cmp_bit(port_a_bit3_pin_out, p ^ tone, "tone level");
  endtask
  ////////////////////////////////////////////////////////////
  always @(posedge mclk_in) begin
    if (rd_q) begin
      if (notes.size() == 0) fail("read without note");
      else cmp_rd(notes.pop_front());
    end
    rd_q <= reg_rd_in;
  end

  initial begin
    logic [15:0] v;
    logic [7:0]  b;
    int          n;
    repeat (4) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    rd(8'h0e, 8'h08, 8'hff);
    rd(8'h11, 8'h08, 8'hff);
    rd(8'h12, 8'hff, 8'hff);
    rd(8'h0b, 8'h00, 8'hff);
    rd(8'h20, 8'h00, 8'hff);
    $display("test reset values done");
    // Start values are always loaded before run is set
    wr(8'h0e, 8'h80);
    repeat (3) begin
      v = 16'($random(seed));
      wr(8'h0d, v[7:0]);
      wr(8'h0c, v[15:8]);
      wr(8'h0d, ~v[7:0]);
      repeat (40) @(posedge mclk_in);
      rd(8'h0c, v[15:8], 8'hff);
      rd(8'h0d, v[7:0], 8'hff);
    end
    $display("test stopped load done");
    wr(8'h0d, 8'hf0);
    wr(8'h0c, 8'hff);
    wr(8'h0b, 8'h04);
    wr(8'h0e, 8'h93);
    wr(8'h0d, 8'h00);
    wr(8'h0c, 8'h00);
    rd(8'h0c, 8'hff, 8'hff);
    wait_wake(n);
    cmp_bit(counter0_irq_out, 1'b1, "irq after overflow");
    rd(8'h0c, 8'h00, 8'hff);
    rd(8'h0e, 8'h93, 8'hff);
    rd(8'h0b, 8'h24, 8'hff);
    wr(8'h0e, 8'h83);
    wr(8'h0b, 8'h00);
    rd(8'h0b, 8'h00, 8'hff);
    // Prescaler code 3 gives one tick every 8 clocks, so 64 clocks hold exactly 8
    n = 0;
    repeat (64) begin
      @(posedge mclk_in);
      if (pwm_clk_tick_out === 1'b1) n++;
    end
    cmp_num(n, 8, "pwm tick rate");
    $display("test timer overflow done");
    wr(8'h0d, 8'hff);
    wr(8'h0c, 8'hff);
    for (int c = 0; c < 8; c++) begin
      period(8'h0e, 8'h90 | 8'(c), 1 << (c < 2 ? 1 : c), 1'b1);
    end
    cmp_bit(counter0_irq_out, 1'b0, "masked irq");
    rd(8'h0b, 8'h20, 8'hff);
    wr(8'h0e, 8'h80);
    wr(8'h0b, 8'h08);
    wr(8'h10, 8'hfe);
    wr(8'h0f, 8'hff);
    period(8'h11, 8'h90, 8, 1'b0);
    cmp_bit(counter1_irq_out, 1'b1, "counter 1 irq");
    wr(8'h12, 8'hf7);
    repeat (3) @(posedge mclk_in);
    cmp_bit(port_a_bit3_pin_out, 1'b0, "tone disabled");
    wr(8'h11, 8'h80);
    $display("test prescaler and tone done");
    for (int k = 0; k < 2; k++) begin
      for (int e = 0; e < 2; e++) begin
        b = 8'h0c + 8'(3 * k);
        wr(b + 8'h02, 8'h40 | 8'(e << 3));
        wr(b + 8'h01, 8'h00);
        wr(b, 8'h00);
        wr(b + 8'h02, 8'h50 | 8'(e << 3));
        pulse(2'(1 << k), 8'h14);
        repeat (6) @(posedge mclk_in);
        rd(b, 8'h00, 8'hff);
        rd(b + 8'h01, 8'(1 - e), 8'hff);
        repeat (30) @(posedge mclk_in);
        rd(b, 8'h00, 8'hff);
        rd(b + 8'h01, 8'h01, 8'hff);
      end
    end
    $display("test event edges done");
    wr(8'h0e, 8'hc9);
    wr(8'h0d, 8'h00);
    wr(8'h0c, 8'h00);
    wr(8'h0e, 8'hd9);
    pulse(2'h1, 8'h28);
    repeat (60) @(posedge mclk_in);
    rd(8'h0c, 8'h00, 8'hff);
    rd(8'h0d, 8'h14, 8'hf0);
    rd(8'h0e, 8'hc9, 8'hff);
    repeat (5) @(posedge mclk_in);
    $display("test pulse width done");
    end_sim();
  end
endmodule

bind dtc_top dtc_top_assertions chk_u (
  .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .counter0_pin_in(counter0_pin_in),
  .counter1_pin_in(counter1_pin_in), .reg_rdata_out(reg_rdata_out), .port_a_bit3_pin_out(port_a_bit3_pin_out),
  .counter0_irq_out(counter0_irq_out), .counter1_irq_out(counter1_irq_out), .wake_out(wake_out),
  .pwm_clk_tick_out(pwm_clk_tick_out));
